// file: common/fbd_pkg.sv
// Constants for the four-byte float to fixed-point decoder
package fbd_pkg;
   localparam int          FBD_BYTES      = 4;
   localparam int          FBD_EXP_W      = 8;
   localparam int          FBD_FRAC_W     = 23;
   localparam int          FBD_INT_W      = 32;
   localparam int          FBD_FRC_W      = 32;
   localparam int          FBD_FIX_W      = FBD_INT_W + FBD_FRC_W;
   localparam int          FBD_SIG_W      = FBD_FRAC_W + 1;
   localparam int          FBD_SIGN_BIT   = 7;
   localparam int          FBD_ELSB_BIT   = 7;
   localparam logic [7:0]  FBD_BIAS       = 8'h7F;
   localparam logic [7:0]  FBD_EXP_ZERO   = 8'h00;
   localparam logic [7:0]  FBD_EXP_ONES   = 8'hFF;
   localparam logic [7:0]  FBD_LOW7_MASK  = 8'h7F;
   localparam logic [1:0]  FBD_BYTE_FIRST = 2'h0;
   localparam logic [1:0]  FBD_BYTE_LAST  = 2'h3;
   localparam logic [9:0]  FBD_SHIFT_MAX  = 10'h020;
   localparam logic [9:0]  FBD_SHIFT_MIN  = 10'h3C0;
   typedef enum logic [1:0] {
      FBD_CLS_NORMAL,
      FBD_CLS_ZERO_SUB,
      FBD_CLS_INF_NAN
   } fbd_class_e;
endpackage

// file: core/fbd_byte_store.sv
// Four-byte store that assembles the received word
`timescale 1ns/1ps
module fbd_byte_store
   import fbd_pkg::*;
(
   // Clock and reset
   input  wire logic        clk_i,
   input  wire logic        reset_i,
   // Write side
   input  wire logic        wr_i,
   input  wire logic [1:0]  wr_idx_i,
   input  wire logic [7:0]  wr_data_i,
   // Read side
   output logic      [31:0] word_o
);
   logic [7:0] mem_reg [FBD_BYTES];

   always_ff @(posedge clk_i or posedge reset_i) begin
      if (reset_i) begin
         for (int i = 0; i < FBD_BYTES; i++) begin
            mem_reg[i] <= 8'h00;
         end
      end else if (wr_i) begin
         mem_reg[wr_idx_i] <= wr_data_i;
      end
   end

   // First byte lands in the top of the word
   always_ff @(posedge clk_i or posedge reset_i) begin
      if (reset_i) begin
         word_o <= 32'h0000_0000;
      end else begin
         word_o <= {mem_reg[0], mem_reg[1], mem_reg[2], mem_reg[3]};
      end
   end
endmodule

// file: core/fbd_decoder.sv
// Host-side decoder: four received float bytes to signed fixed point
`timescale 1ns/1ps
module fbd_decoder
   import fbd_pkg::*;
(
   // Clock and reset
   input  wire logic                 clk_i,
   input  wire logic                 reset_i,
   // Byte stream from the measuring module
   input  wire logic                 byte_valid_i,
   input  wire logic                 byte_first_i,
   input  wire logic [7:0]           byte_data_i,
   // Decoded value
   output logic                      result_valid_o,
   output logic                      sign_o,
   output logic [FBD_EXP_W-1:0]      biased_power_field_o,
   output logic [FBD_FRAC_W-1:0]     fraction_o,
   output logic signed [9:0]         power_o,
   output logic [FBD_INT_W-1:0]      int_part_o,
   output logic [FBD_FRC_W-1:0]      frac_part_o,
   output logic signed [FBD_FIX_W:0] fixed_o,
   output logic                      zero_sub_o,
   output logic                      inf_nan_o,
   output logic                      overflow_o
);
   typedef enum logic [2:0] {
      FBD_ST_COLLECT,
      FBD_ST_WAIT_MEM,
      FBD_ST_WAIT_WORD,
      FBD_ST_DECODE
   } fbd_state_e;

   fbd_state_e       state_reg;
   logic [1:0]       idx_reg;
   logic [31:0]      word;
   logic             store_wr;
   logic             sign_w;
   logic [7:0]       bexp_w;
   logic [22:0]      frac_w;
   logic signed [9:0] power_w;
   logic [FBD_SIG_W-1:0] sig_w;
   logic [FBD_FIX_W-1:0] mag_w;
   fbd_class_e       cls_w;
   logic             ovf_w;
   logic             decode_w;
   logic             take_w;

   // Signed exponent from the biased field
   function automatic logic signed [9:0] fbd_unbias(input logic [7:0] f);
      fbd_unbias = $signed({2'b00, f}) - $signed({2'b00, FBD_BIAS});
   endfunction

   // Extract a byte as the low seven bits
   function automatic logic [6:0] fbd_low7(input logic [7:0] b);
      logic [7:0] m;
      m = b & FBD_LOW7_MASK;
      fbd_low7 = m[6:0];
   endfunction

   // Only the start marker may open a word; stray bytes are dropped until then
   assign store_wr = byte_valid_i && (state_reg == FBD_ST_COLLECT)
                     && (byte_first_i || idx_reg != FBD_BYTE_FIRST);

   fbd_byte_store u_store (
      .clk_i     (clk_i),
      .reset_i   (reset_i),
      .wr_i      (store_wr),
      .wr_idx_i  (idx_reg),
      .wr_data_i (byte_data_i),
      .word_o    (word)
   );

   // Field split by copy and mask
   always_comb begin
      sign_w = word[24 + FBD_SIGN_BIT];
      bexp_w = {fbd_low7(word[31:24]), word[16 + FBD_ELSB_BIT]};
      frac_w = {fbd_low7(word[23:16]), word[15:8], word[7:0]};
   end

   always_comb begin
      power_w = fbd_unbias(bexp_w);
      sig_w   = {1'b1, frac_w};
      if (bexp_w == FBD_EXP_ZERO) begin
         cls_w = FBD_CLS_ZERO_SUB;
      end else if (bexp_w == FBD_EXP_ONES) begin
         cls_w = FBD_CLS_INF_NAN;
      end else begin
         cls_w = FBD_CLS_NORMAL;
      end
   end

   // Binary point sits after bit FBD_FRC_W of the fixed value
   always_comb begin
      logic [FBD_FIX_W+FBD_SIG_W-1:0] wide;
      logic [9:0] sh;
      wide  = '0;
      sh    = 10'h000;
      ovf_w = 1'b0;
      wide[FBD_SIG_W-1:0] = sig_w;
      // Align the hidden one at 2^0, then shift by the power
      wide = wide << (FBD_FRC_W - FBD_FRAC_W);
      if (power_w >= $signed(FBD_SHIFT_MAX)) begin
         ovf_w = 1'b1;
      end else if (power_w >= 0) begin
         sh   = power_w;
         wide = wide << sh;
      end else if (power_w > $signed(FBD_SHIFT_MIN)) begin
         sh   = -power_w;
         wide = wide >> sh;
      end else begin
         wide = '0;
      end
      mag_w = wide[FBD_FIX_W-1:0];
   end

   // Decode cycle and whether the normal formula applies
   assign decode_w = (state_reg == FBD_ST_DECODE);
   assign take_w   = (cls_w == FBD_CLS_NORMAL) && !ovf_w;

   // Byte position within the word
   always_ff @(posedge clk_i or posedge reset_i) begin
      if (reset_i) begin
         idx_reg <= FBD_BYTE_FIRST;
      end else if (store_wr) begin
         if (idx_reg == FBD_BYTE_LAST) begin
            idx_reg <= FBD_BYTE_FIRST;
         end else begin
            idx_reg <= idx_reg + 2'h1;
         end
      end
   end

   // Collect, let the store settle, then decode once
   always_ff @(posedge clk_i or posedge reset_i) begin
      if (reset_i) begin
         state_reg <= FBD_ST_COLLECT;
      end else begin
         case (state_reg)
            FBD_ST_COLLECT: begin
               if (store_wr && idx_reg == FBD_BYTE_LAST) begin
                  state_reg <= FBD_ST_WAIT_MEM;
               end
            end
            FBD_ST_WAIT_MEM: begin
               state_reg <= FBD_ST_WAIT_WORD;
            end
            FBD_ST_WAIT_WORD: begin
               state_reg <= FBD_ST_DECODE;
            end
            FBD_ST_DECODE: begin
               state_reg <= FBD_ST_COLLECT;
            end
            default: begin
               state_reg <= FBD_ST_COLLECT;
            end
         endcase
      end
   end

   // Result strobe, one cycle per word
   always_ff @(posedge clk_i or posedge reset_i) begin
      if (reset_i) begin
         result_valid_o <= 1'b0;
      end else begin
         result_valid_o <= decode_w;
      end
   end

   // Raw fields, held until the next word
   always_ff @(posedge clk_i or posedge reset_i) begin
      if (reset_i) begin
         sign_o               <= 1'b0;
         biased_power_field_o <= 8'h00;
         fraction_o           <= 23'h000000;
         power_o              <= 10'sh000;
      end else if (decode_w) begin
         sign_o               <= sign_w;
         biased_power_field_o <= bexp_w;
         fraction_o           <= frac_w;
         power_o              <= power_w;
      end
   end

   // Class flags
   always_ff @(posedge clk_i or posedge reset_i) begin
      if (reset_i) begin
         zero_sub_o <= 1'b0;
         inf_nan_o  <= 1'b0;
         overflow_o <= 1'b0;
      end else if (decode_w) begin
         zero_sub_o <= (cls_w == FBD_CLS_ZERO_SUB);
         inf_nan_o  <= (cls_w == FBD_CLS_INF_NAN);
         overflow_o <= (cls_w == FBD_CLS_NORMAL) && ovf_w;
      end
   end

   // Magnitude parts, zero for flagged words
   always_ff @(posedge clk_i or posedge reset_i) begin
      if (reset_i) begin
         int_part_o  <= 32'h0000_0000;
         frac_part_o <= 32'h0000_0000;
      end else if (decode_w) begin
         if (take_w) begin
            int_part_o  <= mag_w[FBD_FIX_W-1:FBD_FRC_W];
            frac_part_o <= mag_w[FBD_FRC_W-1:0];
         end else begin
            int_part_o  <= 32'h0000_0000;
            frac_part_o <= 32'h0000_0000;
         end
      end
   end

   // Signed value
   always_ff @(posedge clk_i or posedge reset_i) begin
      if (reset_i) begin
         fixed_o <= 65'sh0;
      end else if (decode_w) begin
         if (take_w) begin
            fixed_o <= sign_w ? -$signed({1'b0, mag_w})
                              : $signed({1'b0, mag_w});
         end else begin
            fixed_o <= 65'sh0;
         end
      end
   end
endmodule

// file: testbench/fbd_chk.sv
// Port checker for the float byte decoder
`timescale 1ns/1ps
module fbd_chk
   import fbd_pkg::*;
(
   // Clock and reset
   input wire logic                       clk_i,
   input wire logic                       reset_i,
   // Byte stream
   input wire logic                       byte_valid_i,
   input wire logic                       byte_first_i,
   input wire logic [7:0]                 byte_data_i,
   // Decoded value
   input wire logic                       result_valid_o,
   input wire logic                       sign_o,
   input wire logic                       zero_sub_o,
   input wire logic                       inf_nan_o,
   input wire logic                       overflow_o,
   input wire logic [FBD_EXP_W-1:0] biased_power_field_o,
   input wire logic [FBD_FRAC_W-1:0] fraction_o,
   input wire logic signed [9:0] power_o,
   input wire logic [FBD_INT_W-1:0] int_part_o,
   input wire logic [FBD_FRC_W-1:0] frac_part_o,
   input wire logic signed [FBD_FIX_W:0] fixed_o
);
   wire logic flg = zero_sub_o | inf_nan_o | overflow_o;
   wire logic signed [64:0] mag = $signed({1'b0, int_part_o, frac_part_o});
   default clocking @(posedge clk_i); endclocking
   default disable iff (reset_i);
   property p_pow; result_valid_o |-> power_o == $signed({2'b00, biased_power_field_o}) - 10'sd127; endproperty
   a_pow: assert property (p_pow) else $error("power offset wrong");
   property p_cls; result_valid_o |-> zero_sub_o == (biased_power_field_o == 8'h00)
      && inf_nan_o == (biased_power_field_o == 8'hFF); endproperty
   a_cls: assert property (p_cls) else $error("class flags wrong");
   property p_ovf; result_valid_o && !zero_sub_o && !inf_nan_o |-> overflow_o == (power_o >= 10'sd32); endproperty
   a_ovf: assert property (p_ovf) else $error("overflow flag wrong");
   property p_flz; flg |-> fixed_o == 65'h0 && int_part_o == 32'h0 && frac_part_o == 32'h0; endproperty
   a_flz: assert property (p_flz) else $error("flagged value not zero");
   property p_pos; result_valid_o && !sign_o |-> fixed_o == mag; endproperty
   a_pos: assert property (p_pos) else $error("positive fixed wrong");
   property p_neg; result_valid_o && sign_o |-> fixed_o == -mag; endproperty
   a_neg: assert property (p_neg) else $error("negative fixed wrong");
   property p_one; result_valid_o && !flg && power_o == 10'sd0 |->
      int_part_o == 32'h1 && frac_part_o == {fraction_o, 9'h000}; endproperty
   a_one: assert property (p_one) else $error("hidden one missing");
   property p_half; result_valid_o && !flg && power_o == -10'sd1 |->
      int_part_o == 32'h0 && frac_part_o == {1'b1, fraction_o, 8'h00}; endproperty
   a_half: assert property (p_half) else $error("point placement wrong");
   property p_pls; result_valid_o |=> !result_valid_o [*3]; endproperty
   a_pls: assert property (p_pls) else $error("result pulse too long");
   property p_hold; !result_valid_o |-> $stable(fixed_o) && $stable(sign_o); endproperty
   a_hold: assert property (p_hold) else $error("result moved between pulses");
endmodule
bind fbd_decoder fbd_chk u_chk (.*);

// file: testbench/fbd_src_model.sv
// Measuring-side model that sends one float as four bytes
`timescale 1ns/1ps
module fbd_src_model (
   input  wire logic        clk_i, go_i, slow_i,
   input  wire logic [31:0] word_i,
   output logic             vld_o, first_o,
   output logic [7:0]       data_o
);
   initial begin
      vld_o = 1'b0;
      first_o = 1'b0;
      data_o = 8'h00;
      forever begin
         @(posedge clk_i);
         if (go_i) begin
            for (int i = 0; i < 4; i++) begin
               #1 vld_o = 1'b1;
               first_o = (i == 0);
               data_o = word_i[31 - 8 * i -: 8];
               @(posedge clk_i);
               #1 vld_o = 1'b0;
               first_o = 1'b0;
               data_o = ~data_o;
               if (slow_i) @(posedge clk_i);
            end
         end
      end
   end
endmodule

// file: testbench/testbench.sv
// Self-checking bench for the float byte decoder
`timescale 1ns/1ps
module testbench;
   logic clk_i, reset_i, go, slow, vld, first, result_valid_o, sign_o;
   logic zero_sub_o, inf_nan_o, overflow_o;
   logic [7:0] data, biased_power_field_o;
   logic [31:0] word, w, int_part_o, frac_part_o;
   logic [22:0] fraction_o;
   logic signed [9:0] power_o;
   logic signed [64:0] fixed_o;
   int n_fail, num_checks;
   logic [31:0] cases [10] = '{32'h3F400000, 32'hC0C00000, 32'h40400000, 32'hC0100000,
      32'hBE800000, 32'h00000000, 32'h7F800000, 32'h4F800000, 32'h4F7FFFFF, 32'h3F800000};
   fbd_src_model i_src (.clk_i(clk_i), .go_i(go), .slow_i(slow), .word_i(word),
      .vld_o(vld), .first_o(first), .data_o(data));
   fbd_decoder i_dut (.clk_i, .reset_i, .byte_valid_i(vld), .byte_first_i(first),
      .byte_data_i(data), .result_valid_o, .sign_o, .biased_power_field_o, .fraction_o,
      .power_o, .int_part_o, .frac_part_o, .fixed_o, .zero_sub_o, .inf_nan_o, .overflow_o);
   task automatic test_done;
      if (n_fail == 0 && num_checks > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask
   task automatic chk(input logic [64:0] got, input logic [64:0] exp);
      num_checks++;
      if (got !== exp) begin
         n_fail++;
         $display("[ERR] %0t got %0h exp %0h", $time, got, exp);
      end
   endtask
   // Expected magnitude in 32.32 fixed point
   function automatic logic [63:0] emag(input logic [31:0] v);
      int p;
      logic [63:0] m;
      p = int'(v[30:23]) - 127;
      m = {40'h0, 1'b1, v[22:0]};
      if (v[30:23] == 8'h00 || v[30:23] == 8'hFF || p >= 32) return 64'h0;
      return (p + 9 >= 0) ? m << (p + 9) : m >> (-(p + 9));
   endfunction
   task automatic run(input logic [31:0] v, input logic s);
      int k;
      logic [63:0] m;
      word = v;
      slow = s;
      go = 1'b1;
      @(posedge clk_i);
      #1 go = 1'b0;
      k = 0;
      while (result_valid_o !== 1'b1 && k < 30) begin
         @(posedge clk_i);
         #1 k++;
      end
      m = emag(v);
      chk(result_valid_o, 1'b1);
      chk(sign_o, v[31]);
      chk(biased_power_field_o, v[30:23]);
      chk(fraction_o, v[22:0]);
      chk(power_o, $signed({2'b00, v[30:23]}) - 10'sd127);
      chk(zero_sub_o, v[30:23] == 8'h00);
      chk(inf_nan_o, v[30:23] == 8'hFF);
      chk(overflow_o, v[30:23] != 8'hFF && v[30:23] >= 8'h9F);
      chk({int_part_o, frac_part_o}, m);
      chk(fixed_o, v[31] ? -{1'b0, m} : {1'b0, m});
   endtask
   initial begin
      clk_i = 1'b0;
      forever #5 clk_i = ~clk_i;
   end
   initial begin
      #100000;
      n_fail++;
      test_done;
   end
   initial begin
      n_fail = 0;
      num_checks = 0;
      go = 1'b0;
      slow = 1'b0;
      word = 32'h0;
      reset_i = 1'b1;
      void'($urandom(32'h5734));
      repeat (6) @(posedge clk_i);
      #1 reset_i = 1'b0;
      foreach (cases[i]) run(cases[i], 1'(i));
      reset_i = 1'b1;
      @(posedge clk_i);
      #1 reset_i = 1'b0;
      chk(result_valid_o, 1'b0);
      chk(fixed_o, 65'h0);
      chk({int_part_o, frac_part_o}, 64'h0);
      repeat (40) begin
         w = $urandom;
         w[30:23] = 8'h64 + 8'($urandom % 60);
         run(w, 1'($urandom % 2));
      end
      test_done;
   end
endmodule
